// [src/dpa_pkg.sv]
// Purpose: shared constants of the dual parallel io adapter
// Assumes: 8-bit processor data bus, two-bit register select
// Notes:   control bits 7:6 are read-only event flags
package dpa_pkg;
    // -----------------------------------------------------------------
    // widths
    // -----------------------------------------------------------------
    localparam int DPA_WIDTH     = 8;
    localparam int DPA_CTL_WIDTH = 6;
    localparam int DPA_SYNC_W    = DPA_WIDTH + 2;

    // -----------------------------------------------------------------
    // register select decode
    // -----------------------------------------------------------------
    localparam logic [1:0] DPA_RS_DATA_A = 2'h0;
    localparam logic [1:0] DPA_RS_CTRL_A = 2'h1;
    localparam logic [1:0] DPA_RS_DATA_B = 2'h2;
    localparam logic [1:0] DPA_RS_CTRL_B = 2'h3;
    localparam int         DPA_RS_SIDE   = 1;
    localparam int         DPA_RS_CTRL   = 0;

    // -----------------------------------------------------------------
    // control field positions
    // -----------------------------------------------------------------
    localparam int DPA_CTL_IRQ1_EN = 0;
    localparam int DPA_CTL_EDGE1   = 1;
    localparam int DPA_CTL_SEL     = 2;
    localparam int DPA_CTL_LINE2_V = 3;
    localparam int DPA_CTL_EDGE2   = 4;
    localparam int DPA_CTL_LINE2_O = 5;
    localparam int DPA_SYNC_AUX1   = DPA_WIDTH;
    localparam int DPA_SYNC_AUX2   = DPA_WIDTH + 1;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [DPA_WIDTH-1:0]     DPA_DIR_RST  = 8'h00;
    localparam logic [DPA_WIDTH-1:0]     DPA_DATA_RST = 8'h00;
    localparam logic [DPA_CTL_WIDTH-1:0] DPA_CTL_RST  = 6'h00;
endpackage

// [src/dpa_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes:   only the second stage leaves this module
`timescale 1ns/10ps
module dpa_sync #(
    parameter int WIDTH = 10
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// [src/dpa_adapter.sv]
// Purpose: dual 8-bit parallel io adapter behind chip and register selects
// Assumes: one access per bus_strobe pulse, read data one cycle later
// Notes:   flags clear on a data read; an edge in the same cycle wins
// Operation
// - two independent 8-line ports A and B behave identically.
// - each port holds a data, a direction and a control register.
// - the data register carries values between the bus and the port lines.
// - the direction register sets each of the eight lines as input or output.
// - direction bit zero makes a line an input, one makes it drive, mixed allowed.
// - four locations are decoded from chip select and register select.
// - two locations reach the shared data-or-direction slots, two the controls.
// - control bit 2 low reaches direction, high reaches data.
// - each port has two extra lines used as interrupt inputs; the second can instead drive as an output.
// - the remaining control bits choose the function of the extra lines.
`timescale 1ns/10ps
module dpa_adapter
    import dpa_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 bus_cs,
    input  wire logic [1:0]           bus_rs,
    input  wire logic                 bus_rd,
    input  wire logic                 bus_strobe,
    input  wire logic [DPA_WIDTH-1:0] bus_wdata,
    output logic      [DPA_WIDTH-1:0] bus_rdata,
    output logic                      bus_ack,
    input  wire logic [DPA_WIDTH-1:0] port_a_in,
    output logic      [DPA_WIDTH-1:0] port_a_out,
    output logic      [DPA_WIDTH-1:0] port_a_oe_n,
    input  wire logic                 aux_line_one_a,
    input  wire logic                 aux_line_two_a_in,
    output logic                      aux_line_two_a_out,
    output logic                      aux_line_two_a_oe_n,
    output logic                      irq_a,
    input  wire logic [DPA_WIDTH-1:0] port_b_in,
    output logic      [DPA_WIDTH-1:0] port_b_out,
    output logic      [DPA_WIDTH-1:0] port_b_oe_n,
    input  wire logic                 aux_line_one_b,
    input  wire logic                 aux_line_two_b_in,
    output logic                      aux_line_two_b_out,
    output logic                      aux_line_two_b_oe_n,
    output logic                      irq_b
);
    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [DPA_SYNC_W-1:0] sync_q    [2];
    logic [1:0]            aux_prev_reg [2];

    dpa_sync #(.WIDTH(DPA_SYNC_W)) u_sync_a (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({aux_line_two_a_in, aux_line_one_a, port_a_in}),
        .sync_out (sync_q[0])
    );

    dpa_sync #(.WIDTH(DPA_SYNC_W)) u_sync_b (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({aux_line_two_b_in, aux_line_one_b, port_b_in}),
        .sync_out (sync_q[1])
    );

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [DPA_WIDTH-1:0]     dir_reg   [2];
    logic [DPA_WIDTH-1:0]     dir_next  [2];
    logic [DPA_WIDTH-1:0]     data_reg  [2];
    logic [DPA_WIDTH-1:0]     data_next [2];
    logic [DPA_CTL_WIDTH-1:0] ctrl_reg  [2];
    logic [DPA_CTL_WIDTH-1:0] ctrl_next [2];
    logic [DPA_WIDTH-1:0]     oe_n_reg  [2];
    logic [DPA_WIDTH-1:0]     oe_n_next [2];
    logic [1:0]               flag1_reg;
    logic [1:0]               flag1_next;
    logic [1:0]               flag2_reg;
    logic [1:0]               flag2_next;
    logic [1:0]               irq_reg;
    logic [1:0]               irq_next;
    logic [1:0]               aux2_out_reg;
    logic [1:0]               aux2_out_next;
    logic [1:0]               aux2_oe_n_reg;
    logic [1:0]               aux2_oe_n_next;
    logic [DPA_WIDTH-1:0]     rdata_reg;
    logic [DPA_WIDTH-1:0]     rdata_next;
    logic                     ack_reg;
    logic                     ack_next;
    logic                     access;
    logic                     side;
    logic                     is_ctrl;

    // input lines read the pin, output lines read back the latch
    function automatic logic [DPA_WIDTH-1:0] dpa_line_read(
        input logic [DPA_WIDTH-1:0] dir,
        input logic [DPA_WIDTH-1:0] latch,
        input logic [DPA_WIDTH-1:0] pins
    );
        dpa_line_read = (dir & latch) | (~dir & pins);
    endfunction

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    assign access  = bus_strobe & bus_cs;
    assign side    = bus_rs[DPA_RS_SIDE];
    assign is_ctrl = bus_rs[DPA_RS_CTRL];

    always_comb begin
        logic edge1;
        logic edge2;
        logic sel_hit;
        edge1          = 1'b0;
        edge2          = 1'b0;
        sel_hit        = 1'b0;
        rdata_next     = rdata_reg;
        ack_next       = access;
        flag1_next     = flag1_reg;
        flag2_next     = flag2_reg;
        irq_next       = irq_reg;
        aux2_out_next  = aux2_out_reg;
        aux2_oe_n_next = aux2_oe_n_reg;
        for (int p = 0; p < 2; p++) begin
            dir_next[p]  = dir_reg[p];
            data_next[p] = data_reg[p];
            ctrl_next[p] = ctrl_reg[p];
            sel_hit      = access && (side == p[0]);
            // polarity of each aux edge is software chosen
            edge1 = ctrl_reg[p][DPA_CTL_EDGE1] ?
                (sync_q[p][DPA_SYNC_AUX1] & ~aux_prev_reg[p][0]) :
                (~sync_q[p][DPA_SYNC_AUX1] & aux_prev_reg[p][0]);
            edge2 = ~ctrl_reg[p][DPA_CTL_LINE2_O] & (ctrl_reg[p][DPA_CTL_EDGE2] ?
                (sync_q[p][DPA_SYNC_AUX2] & ~aux_prev_reg[p][1]) :
                (~sync_q[p][DPA_SYNC_AUX2] & aux_prev_reg[p][1]));
            if (sel_hit && !bus_rd) begin
                if (is_ctrl) begin
                    ctrl_next[p] = bus_wdata[DPA_CTL_WIDTH-1:0];
                end else if (ctrl_reg[p][DPA_CTL_SEL]) begin
                    data_next[p] = bus_wdata;
                end else begin
                    dir_next[p] = bus_wdata;
                end
            end
            if (sel_hit && bus_rd) begin
                if (is_ctrl) begin
                    rdata_next = {flag1_reg[p], flag2_reg[p], ctrl_reg[p]};
                end else if (ctrl_reg[p][DPA_CTL_SEL]) begin
                    rdata_next = dpa_line_read(dir_reg[p], data_reg[p],
                                               sync_q[p][DPA_WIDTH-1:0]);
                    flag1_next[p] = 1'b0;
                    flag2_next[p] = 1'b0;
                end else begin
                    rdata_next = dir_reg[p];
                end
            end
            // set after clear so an edge in the clearing cycle is kept
            if (edge1) begin
                flag1_next[p] = 1'b1;
            end
            if (edge2) begin
                flag2_next[p] = 1'b1;
            end
            irq_next[p] = (flag1_reg[p] & ctrl_reg[p][DPA_CTL_IRQ1_EN]) |
                          (flag2_reg[p] & ctrl_reg[p][DPA_CTL_LINE2_V] &
                           ~ctrl_reg[p][DPA_CTL_LINE2_O]);
            aux2_out_next[p]  = ctrl_next[p][DPA_CTL_LINE2_V];
            aux2_oe_n_next[p] = ~ctrl_next[p][DPA_CTL_LINE2_O];
            oe_n_next[p]      = ~dir_next[p];
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < 2; p++) begin
                dir_reg[p]      <= DPA_DIR_RST;
                data_reg[p]     <= DPA_DATA_RST;
                ctrl_reg[p]     <= DPA_CTL_RST;
                oe_n_reg[p]     <= ~DPA_DIR_RST;
                aux_prev_reg[p] <= 2'h0;
            end
            flag1_reg     <= 2'h0;
            flag2_reg     <= 2'h0;
            irq_reg       <= 2'h0;
            aux2_out_reg  <= 2'h0;
            aux2_oe_n_reg <= 2'h3;
            rdata_reg     <= 8'h00;
            ack_reg       <= 1'b0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                dir_reg[p]      <= dir_next[p];
                data_reg[p]     <= data_next[p];
                ctrl_reg[p]     <= ctrl_next[p];
                oe_n_reg[p]     <= oe_n_next[p];
                aux_prev_reg[p] <= sync_q[p][DPA_SYNC_AUX2:DPA_SYNC_AUX1];
            end
            flag1_reg     <= flag1_next;
            flag2_reg     <= flag2_next;
            irq_reg       <= irq_next;
            aux2_out_reg  <= aux2_out_next;
            aux2_oe_n_reg <= aux2_oe_n_next;
            rdata_reg     <= rdata_next;
            ack_reg       <= ack_next;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign bus_rdata           = rdata_reg;
    assign bus_ack             = ack_reg;
    assign port_a_out          = data_reg[0];
    assign port_a_oe_n         = oe_n_reg[0];
    assign aux_line_two_a_out  = aux2_out_reg[0];
    assign aux_line_two_a_oe_n = aux2_oe_n_reg[0];
    assign irq_a               = irq_reg[0];
    assign port_b_out          = data_reg[1];
    assign port_b_oe_n         = oe_n_reg[1];
    assign aux_line_two_b_out  = aux2_out_reg[1];
    assign aux_line_two_b_oe_n = aux2_oe_n_reg[1];
    assign irq_b               = irq_reg[1];

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    dir_write_a: assert property (
        (access && !bus_rd && bus_rs == DPA_RS_DATA_A && !ctrl_reg[0][DPA_CTL_SEL])
        |=> (dir_reg[0] == $past(bus_wdata)) && (data_reg[0] == $past(data_reg[0])))
        else $error("direction write on side a lost");
    data_write_b: assert property (
        (access && !bus_rd && bus_rs == DPA_RS_DATA_B && ctrl_reg[1][DPA_CTL_SEL])
        |=> (port_b_out == $past(bus_wdata)) && (dir_reg[1] == $past(dir_reg[1])))
        else $error("data write on side b lost");
    ctrl_write_b: assert property (
        (access && !bus_rd && bus_rs == DPA_RS_CTRL_B)
        |=> (ctrl_reg[1] == $past(bus_wdata[DPA_CTL_WIDTH-1:0])) && $stable(dir_reg[1]))
        else $error("control write on side b wrong");
    side_isolate_a: assert property (
        (access && !bus_rd && !side) |=> $stable(dir_reg[1]) && $stable(data_reg[1]))
        else $error("side a write disturbed side b");
    drive_enable_a: assert property (
        (access && !bus_rd && bus_rs == DPA_RS_DATA_A && !ctrl_reg[0][DPA_CTL_SEL])
        |=> port_a_oe_n == ~$past(bus_wdata))
        else $error("side a enables do not follow direction");
    read_data_a: assert property (
        (access && bus_rd && bus_rs == DPA_RS_DATA_A && ctrl_reg[0][DPA_CTL_SEL])
        |=> bus_ack && ((bus_rdata & $past(dir_reg[0])) ==
                        ($past(data_reg[0]) & $past(dir_reg[0]))))
        else $error("side a data read back wrong");
    no_select_ack: assert property (
        !(bus_cs && bus_strobe) |=> !bus_ack)
        else $error("answer without chip select");
    aux_flag_a: assert property (
        ($rose(sync_q[0][DPA_SYNC_AUX1]) && ctrl_reg[0][DPA_CTL_EDGE1]) |=> flag1_reg[0])
        else $error("side a rising edge not flagged");
    irq_gate_a: assert property (
        (flag1_reg[0] && ctrl_reg[0][DPA_CTL_IRQ1_EN]) |=> irq_a)
        else $error("side a request not raised");
    reset_clear: assert property (
        $fell(sys_rst) |-> (port_a_oe_n == 8'hff) && (port_b_oe_n == 8'hff)
                           && (ctrl_reg[0] == 6'h00) && (ctrl_reg[1] == 6'h00))
        else $error("state not cleared by reset");
endmodule

// [verification/dpa_bus_master.sv]
// Purpose: processor-side bus model for the adapter
// Assumes: strobe is a one-cycle pulse, ack one cycle after it
// Notes:   released lines show inverted data, not the last value
`timescale 1ns/10ps
module dpa_bus_master
    import dpa_pkg::*;
(
    input  wire logic                 clock,
    output logic                      bus_cs,
    output logic [1:0]                bus_rs,
    output logic                      bus_rd,
    output logic                      bus_strobe,
    output logic [DPA_WIDTH-1:0]      bus_wdata,
    input  wire logic [DPA_WIDTH-1:0] bus_rdata,
    input  wire logic                 bus_ack
);
    // -----------------------------------------------------------------
    // one access, held until the ack edge or a bounded wait
    // -----------------------------------------------------------------
    initial begin
        bus_cs     = 1'b0;
        bus_rs     = 2'h0;
        bus_rd     = 1'b1;
        bus_strobe = 1'b0;
        bus_wdata  = 8'h00;
    end

    task automatic access(input logic cs, input logic [1:0] rs, input logic rd,
                          input logic [DPA_WIDTH-1:0] wd,
                          output logic [DPA_WIDTH-1:0] rdv, output logic ack);
        int n;
        ack = 1'b0;
        rdv = 8'h00;
        @(negedge clock);
        bus_cs     = cs;  // address decode is the adapter's job
        bus_rs     = rs;
        bus_rd     = rd;
        bus_wdata  = wd;
        bus_strobe = 1'b1;
        @(negedge clock);
        bus_strobe = 1'b0;
        // ack stands mid-cycle; looking at its launching edge would race
        for (n = 0; n < 4; n++) begin
            if (bus_ack === 1'b1) begin
                ack = 1'b1;
                rdv = bus_rdata;
                break;
            end
            @(negedge clock);
        end
        @(negedge clock);
        bus_cs    = 1'b0;
        bus_rs    = ~rs;
        bus_wdata = ~wd;
    endtask
endmodule

// [verification/tb.sv]
// Purpose: self-checking bench for the dual parallel io adapter
// Assumes: bus model drives the register side, pins resolved here
// Notes:   no random stimulus; one watchdog bounds the run
`timescale 1ns/10ps
module tb;
    import dpa_pkg::*;
    logic                 clock, sys_rst, aux1_a, aux1_b, aux2_a, aux2_b;
    logic                 bus_cs, bus_rd, bus_strobe, bus_ack;
    logic [1:0]           bus_rs;
    logic [DPA_WIDTH-1:0] bus_wdata, bus_rdata, ext_a, ext_b;
    logic [DPA_WIDTH-1:0] a_out, a_oe_n, b_out, b_oe_n, rv, dv, pv, xv;
    logic                 a2_out, a2_oe_n, b2_out, b2_oe_n, irq_a, irq_b, k;
    int                   err_total, cmp_count, s;
    // pin level: the adapter wins where it drives, else the outside world
    wire  [DPA_WIDTH-1:0] pin_a = (a_out & ~a_oe_n) | (ext_a & a_oe_n);
    wire  [DPA_WIDTH-1:0] pin_b = (b_out & ~b_oe_n) | (ext_b & b_oe_n);

    dpa_bus_master u_dpa_bus_master (.clock(clock), .bus_cs(bus_cs), .bus_rs(bus_rs),
        .bus_rd(bus_rd), .bus_strobe(bus_strobe), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack));
    dpa_adapter u_dpa_adapter (.clock(clock), .sys_rst(sys_rst), .bus_cs(bus_cs),
        .bus_rs(bus_rs), .bus_rd(bus_rd), .bus_strobe(bus_strobe), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .port_a_in(pin_a), .port_a_out(a_out),
        .port_a_oe_n(a_oe_n), .aux_line_one_a(aux1_a), .aux_line_two_a_in(aux2_a),
        .aux_line_two_a_out(a2_out), .aux_line_two_a_oe_n(a2_oe_n), .irq_a(irq_a),
        .port_b_in(pin_b), .port_b_out(b_out), .port_b_oe_n(b_oe_n),
        .aux_line_one_b(aux1_b), .aux_line_two_b_in(aux2_b), .aux_line_two_b_out(b2_out),
        .aux_line_two_b_oe_n(b2_oe_n), .irq_b(irq_b));

    // -----------------------------------------------------------------
    // compares, accesses, verdict
    // -----------------------------------------------------------------
    task automatic chk_reg(input logic [DPA_WIDTH-1:0] got, input logic [DPA_WIDTH-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] rs, input logic [DPA_WIDTH-1:0] d);
        u_dpa_bus_master.access(1'b1, rs, 1'b0, d, rv, k);
        chk_bit(k, 1'b1);
    endtask
    task automatic rd(input logic [1:0] rs, input logic [DPA_WIDTH-1:0] exp);
        u_dpa_bus_master.access(1'b1, rs, 1'b1, 8'h00, rv, k);
        chk_bit(k, 1'b1);
        chk_reg(rv, exp);
    endtask
    task automatic wrap_up;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // clock and watchdog
    // -----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (4000) @(posedge clock);
        err_total++;
        wrap_up;
    end

    // -----------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------
    initial begin
        err_total = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        {aux1_a, aux1_b, aux2_a, aux2_b} = 4'h0;
        ext_a = 8'hc3;
        ext_b = 8'h5a;
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        rd(DPA_RS_CTRL_A, 8'h00);
        rd(DPA_RS_CTRL_B, 8'h00);
        rd(DPA_RS_DATA_B, 8'h00);
        chk_reg(a_oe_n & b_oe_n, 8'hff);
        for (s = 0; s < 2; s++) begin
            dv = s ? 8'h3c : 8'h0f;
            pv = s ? 8'h96 : 8'ha5;
            xv = s ? ext_b : ext_a;
            wr(s ? DPA_RS_DATA_B : DPA_RS_DATA_A, dv);
            chk_reg(s ? b_oe_n : a_oe_n, ~dv);
            wr(s ? DPA_RS_CTRL_B : DPA_RS_CTRL_A, 8'h04);
            rd(s ? DPA_RS_CTRL_B : DPA_RS_CTRL_A, 8'h04);
            wr(s ? DPA_RS_DATA_B : DPA_RS_DATA_A, pv);
            chk_reg(s ? b_out : a_out, pv);
            rd(s ? DPA_RS_DATA_B : DPA_RS_DATA_A, (dv & pv) | (~dv & xv));
            wr(s ? DPA_RS_CTRL_B : DPA_RS_CTRL_A, 8'h00);
            rd(s ? DPA_RS_DATA_B : DPA_RS_DATA_A, dv);
        end
        chk_reg(a_out, 8'ha5);
        // unselected access must leave the register alone
        u_dpa_bus_master.access(1'b0, DPA_RS_CTRL_A, 1'b0, 8'h3f, rv, k);
        chk_bit(k, 1'b0);
        rd(DPA_RS_CTRL_A, 8'h00);
        // aux one rising edge with its interrupt enabled
        wr(DPA_RS_CTRL_A, 8'h07);
        @(negedge clock);
        aux1_a = 1'b1;
        repeat (6) @(negedge clock);
        chk_bit(irq_a, 1'b1);
        chk_bit(irq_b, 1'b0);
        rd(DPA_RS_CTRL_A, 8'h87);
        rd(DPA_RS_DATA_A, 8'hc5);
        repeat (3) @(negedge clock);
        chk_bit(irq_a, 1'b0);
        rd(DPA_RS_CTRL_A, 8'h07);
        // aux two rising input edge and aux one falling edge together
        wr(DPA_RS_CTRL_A, 8'h1c);
        @(negedge clock);
        {aux1_a, aux2_a} = 2'h1;
        repeat (6) @(negedge clock);
        chk_bit(irq_a, 1'b1);
        rd(DPA_RS_CTRL_A, 8'hdc);
        rd(DPA_RS_DATA_A, 8'hc5);
        repeat (3) @(negedge clock);
        chk_bit(irq_a, 1'b0);
        // aux two as an output on side b
        wr(DPA_RS_CTRL_B, 8'h2c);
        chk_bit(b2_oe_n, 1'b0);
        chk_bit(b2_out, 1'b1);
        chk_bit(a2_oe_n, 1'b1);
        chk_bit(a2_out, 1'b1);
        wr(DPA_RS_CTRL_B, 8'h24);
        chk_bit(b2_out, 1'b0);
        // second reset in mid-run
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        chk_reg(a_oe_n, 8'hff);
        rd(DPA_RS_CTRL_B, 8'h00);
        rd(DPA_RS_DATA_A, 8'h00);
        wrap_up;
    end
endmodule
